// >>> rtl/hbss_cfg.svh
// Constants of the hub boot stage sequencer
// Assumes inclusion by bare name from rtl files
// What this block does
// - Reset low holds standby, ports tristated, PLL off
// - Reset high runs the hub boot stages
// - Standby drops transactions, ports, registers, configuration
// - Reset release enters flash probe, inits defaults
// - Valid flash signature enables external code fetch
// - Bad signature or no SPI strap uses ROM
// - ROM defaults stage loads configuration defaults
// - Strap stage samples select, port, removable, charging straps
// - Configuration 1 goes to pull-up probe
// - Both pull-ups give host-bus configuration, else merge
// - Host-bus stage waits forever for master end
// - Fuse merge picks OTP or host-bus priority
// - Flash firmware keeps only the OTP trim bits under HBSS_TRIM_MASK
// - Connect stage sets attach and superspeed enable bits
// - Normal mode holds until system changes mode
// - Reset low in any stage forces standby
// - Soft disconnect returns to connect stage until negated
`ifndef HBSS_CFG_SVH
`define HBSS_CFG_SVH
`define HBSS_SIG_ADDR 20'h3FFFA
`define HBSS_BOOT_ADDR 20'h00000
`define HBSS_SIG_WORD 32'h32444655
`define HBSS_CFG_ONE 3'h1
`define HBSS_END_REG 8'hFF
`define HBSS_CMD_ATTACH 16'hAA55
`define HBSS_CMD_ATTACH_KEEP 16'hAA56
`define HBSS_NPORT 5
`define HBSS_CFG_W 8
`define HBSS_SIG_BYTES 3'h4
`define HBSS_CFG_WORDS 4
`define HBSS_AW 2
`define HBSS_IDX_ROM 2'h0
`define HBSS_IDX_HOST 2'h1
`define HBSS_IDX_OTP 2'h2
`define HBSS_IDX_PSEUDO 2'h3
`define HBSS_TRIM_MASK 8'hC0
`endif

// >>> rtl/hbss_pkg.sv
// Types of the hub boot stage sequencer
// Assumes the cfg header is compiled alongside
package hbss_pkg;
  typedef enum logic [3:0] {
    HBSS_STANDBY, HBSS_FLASH_PROBE, HBSS_ROM_DEF, HBSS_STRAP_READ, HBSS_PULLUP_PROBE,
    HBSS_HOSTBUS_CFG, HBSS_FUSE_MERGE, HBSS_CONNECT, HBSS_NORMAL
  } hbss_stage_t;
endpackage

// >>> rtl/hbss_cfg_if.sv
// Carrier between sequencer and its configuration store
// Assumes single clock mclk
`timescale 1ns/10ps
`default_nettype none
interface hbss_cfg_if;
  logic we;
  logic [1:0] waddr;
  logic [7:0] wdata;
  logic [1:0] raddr;
  logic [7:0] rdata;
  modport seq (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> rtl/hbss_cfg_mem.sv
// Small configuration store, registered read
// Assumes reset clears it to zero, as standby forgets all
`timescale 1ns/10ps
`default_nettype none
`include "hbss_cfg.svh"
module hbss_cfg_mem (
  input wire logic mclk,
  input wire logic reset,
  hbss_cfg_if.mem bus
);
  logic [7:0] mem_reg [0:`HBSS_CFG_WORDS-1];
  logic [7:0] rd_reg;
  genvar i;
  // ---------------------------------
  // Storage, cleared in standby
  // ---------------------------------
  generate
    for (i = 0; i < `HBSS_CFG_WORDS; i = i + 1) begin : g_w
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          mem_reg[i] <= 8'h00;
        end else if (bus.we && bus.waddr == 2'(i)) begin
          mem_reg[i] <= bus.wdata;
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_reg <= 8'h00;
    end else begin
      rd_reg <= mem_reg[bus.raddr];
    end
  end
  assign bus.rdata = rd_reg;
endmodule
`default_nettype wire

// >>> rtl/hbss_top.sv
// Hub boot stage sequencer, standby through normal mode
// Assumes flash bytes arrive on a simple request/valid port, and the
// host-bus slave decodes register writes and commands outside
`timescale 1ns/10ps
`default_nettype none
`include "hbss_cfg.svh"
module hbss_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic pll_valid_clk,
  input wire logic spi_mode_strap,
  input wire logic [2:0] config_select_straps,
  input wire logic [`HBSS_NPORT-1:0] port_disable_plus_strap,
  input wire logic [`HBSS_NPORT-1:0] port_disable_minus_strap,
  input wire logic nonremovable_strap,
  input wire logic charging_enable_strap,
  output logic flash_req,
  output logic [19:0] flash_addr,
  input wire logic flash_valid,
  input wire logic [7:0] flash_data,
  input wire logic pullup_clk_seen,
  input wire logic pullup_data_seen,
  input wire logic host_wr,
  input wire logic [7:0] host_reg,
  input wire logic [7:0] host_wdata,
  input wire logic host_cmd,
  input wire logic [15:0] host_opcode,
  input wire logic legacy_mode,
  input wire logic [7:0] otp_data,
  input wire logic soft_disconnect,
  output logic ports_hiz,
  output logic pll_run,
  output logic ext_rom_en,
  output logic hostbus_slave,
  output logic keep_hostbus,
  output logic host_attach,
  output logic superspeed_hub_on,
  output logic [`HBSS_NPORT-1:0] port_enable,
  output logic [`HBSS_CFG_W-1:0] merged_cfg,
  output logic [2:0] cfg_select,
  output logic nonremovable,
  output logic charging_en,
  output var hbss_pkg::hbss_stage_t stage
);
  import hbss_pkg::*;
  hbss_cfg_if cif ();
  hbss_cfg_mem u_mem (
    .mclk(mclk),
    .reset(reset),
    .bus(cif)
  );
  // ---------------------------------
  // Stage state
  // ---------------------------------
  hbss_stage_t stage_reg, stage_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [31:0] sig_reg, sig_next;
  logic ext_reg, ext_next;
  logic slave_reg, slave_next;
  logic keep_reg, keep_next;
  logic attach_reg, attach_next;
  logic ss_reg, ss_next;
  logic straps_done_reg, straps_done_next;
  logic [2:0] sel_reg, sel_next;
  logic [`HBSS_NPORT-1:0] pdis_reg, pdis_next;
  logic nrem_reg, nrem_next;
  logic bc_reg, bc_next;
  logic [7:0] cfg_reg, cfg_next;
  logic host_touched_reg, host_touched_next;
  logic [1:0] mph_reg, mph_next;
  logic end_hit;
  assign end_hit = legacy_mode ? (host_wr && host_reg == `HBSS_END_REG) :
    (host_cmd && (host_opcode == `HBSS_CMD_ATTACH ||
    host_opcode == `HBSS_CMD_ATTACH_KEEP));
  always_comb begin
    stage_next = stage_reg;
    cnt_next = cnt_reg;
    sig_next = sig_reg;
    ext_next = ext_reg;
    slave_next = slave_reg;
    keep_next = keep_reg;
    attach_next = attach_reg;
    ss_next = ss_reg;
    straps_done_next = straps_done_reg;
    sel_next = sel_reg;
    pdis_next = pdis_reg;
    nrem_next = nrem_reg;
    bc_next = bc_reg;
    cfg_next = cfg_reg;
    host_touched_next = host_touched_reg;
    mph_next = mph_reg;
    cif.we = 1'b0;
    cif.waddr = `HBSS_IDX_ROM;
    cif.wdata = 8'h00;
    cif.raddr = `HBSS_IDX_ROM;
    case (stage_reg)
      HBSS_STANDBY: begin
        stage_next = HBSS_FLASH_PROBE;
        cnt_next = 3'h0;
      end
      HBSS_FLASH_PROBE: begin
        if (!spi_mode_strap) begin
          stage_next = HBSS_ROM_DEF;
        end else if (pll_valid_clk && flash_valid) begin
          sig_next = {sig_reg[23:0], flash_data};
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == `HBSS_SIG_BYTES - 3'h1) begin
            if ({sig_reg[23:0], flash_data} == `HBSS_SIG_WORD) begin
              ext_next = 1'b1;
            end
            stage_next = HBSS_ROM_DEF;
          end
        end
      end
      HBSS_ROM_DEF: begin
        cif.we = 1'b1;
        cif.waddr = `HBSS_IDX_ROM;
        cif.wdata = 8'h00;
        cfg_next = 8'h00;
        stage_next = HBSS_STRAP_READ;
      end
      HBSS_STRAP_READ: begin
        if (!straps_done_reg) begin
          sel_next = config_select_straps;
          pdis_next = port_disable_plus_strap | port_disable_minus_strap;
          nrem_next = nonremovable_strap;
          bc_next = charging_enable_strap;
          straps_done_next = 1'b1;
        end
        stage_next = (config_select_straps == `HBSS_CFG_ONE) ?
          HBSS_PULLUP_PROBE : HBSS_FUSE_MERGE;
      end
      HBSS_PULLUP_PROBE: begin
        if (pullup_clk_seen && pullup_data_seen) begin
          slave_next = 1'b1;
          stage_next = HBSS_HOSTBUS_CFG;
        end else begin
          stage_next = HBSS_FUSE_MERGE;
        end
      end
      HBSS_HOSTBUS_CFG: begin
        if (host_wr && host_reg != `HBSS_END_REG) begin
          cif.we = 1'b1;
          cif.waddr = `HBSS_IDX_HOST;
          cif.wdata = host_wdata;
          host_touched_next = 1'b1;
        end
        if (end_hit) begin
          keep_next = !legacy_mode && host_opcode == `HBSS_CMD_ATTACH_KEEP;
          stage_next = HBSS_FUSE_MERGE;
        end
      end
      HBSS_FUSE_MERGE: begin
        cif.raddr = `HBSS_IDX_HOST;
        mph_next = mph_reg + 2'h1;
        if (mph_reg == 2'h1) begin
          if (ext_reg) begin
            // Flash firmware: host-bus beats pseudo-OTP, real OTP trim only
            cfg_next = (host_touched_reg ? cif.rdata : 8'h00) |
              (otp_data & `HBSS_TRIM_MASK);
          end else begin
            cfg_next = otp_data != 8'h00 ? otp_data : cif.rdata;
          end
          cif.we = 1'b1;
          cif.waddr = ext_reg ? `HBSS_IDX_PSEUDO : `HBSS_IDX_OTP;
          cif.wdata = cfg_next;
          stage_next = HBSS_CONNECT;
        end
      end
      HBSS_CONNECT: begin
        attach_next = 1'b1;
        ss_next = 1'b1;
        if (!soft_disconnect) begin
          stage_next = HBSS_NORMAL;
        end
      end
      HBSS_NORMAL: begin
        if (soft_disconnect) begin
          stage_next = HBSS_CONNECT;
        end
      end
      default: stage_next = HBSS_STANDBY;
    endcase
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage_reg <= HBSS_STANDBY;
      cnt_reg <= 3'h0;
      sig_reg <= 32'h00000000;
      ext_reg <= 1'b0;
      slave_reg <= 1'b0;
      keep_reg <= 1'b0;
      attach_reg <= 1'b0;
      ss_reg <= 1'b0;
      straps_done_reg <= 1'b0;
      sel_reg <= 3'h0;
      pdis_reg <= 5'h00;
      nrem_reg <= 1'b0;
      bc_reg <= 1'b0;
      cfg_reg <= 8'h00;
      host_touched_reg <= 1'b0;
      mph_reg <= 2'h0;
    end else begin
      stage_reg <= stage_next;
      cnt_reg <= cnt_next;
      sig_reg <= sig_next;
      ext_reg <= ext_next;
      slave_reg <= slave_next;
      keep_reg <= keep_next;
      attach_reg <= attach_next;
      ss_reg <= ss_next;
      straps_done_reg <= straps_done_next;
      sel_reg <= sel_next;
      pdis_reg <= pdis_next;
      nrem_reg <= nrem_next;
      bc_reg <= bc_next;
      cfg_reg <= cfg_next;
      host_touched_reg <= host_touched_next;
      mph_reg <= mph_next;
    end
  end
  // ---------------------------------
  // Outputs
  // ---------------------------------
  // Reset is the active-high form of the chip reset pin
  assign ports_hiz = reset || stage_reg == HBSS_STANDBY;
  assign pll_run = !reset;
  assign flash_req = stage_reg == HBSS_FLASH_PROBE && spi_mode_strap;
  assign flash_addr = ext_reg ? `HBSS_BOOT_ADDR :
    (`HBSS_SIG_ADDR + {17'h00000, cnt_reg});
  assign ext_rom_en = ext_reg;
  assign hostbus_slave = slave_reg;
  assign keep_hostbus = keep_reg;
  assign host_attach = attach_reg && stage_reg != HBSS_CONNECT ||
    attach_reg && !soft_disconnect;
  assign superspeed_hub_on = ss_reg;
  assign port_enable = (stage_reg == HBSS_NORMAL) ? ~pdis_reg :
    {`HBSS_NPORT{1'b0}};
  assign merged_cfg = cfg_reg;
  assign cfg_select = sel_reg;
  assign nonremovable = nrem_reg;
  assign charging_en = bc_reg;
  assign stage = stage_reg;
  // ---------------------------------
  // Checks
  // ---------------------------------
  sequence s_strap_cfg1;
    stage_reg == HBSS_STRAP_READ && config_select_straps == `HBSS_CFG_ONE;
  endsequence
  a_cfg1_probe: assert property (@(posedge mclk) disable iff (reset)
    s_strap_cfg1 |=> stage_reg == HBSS_PULLUP_PROBE) else $error("cfg1 not probed");
  a_other_merge: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_STRAP_READ && config_select_straps != `HBSS_CFG_ONE
    |=> stage_reg == HBSS_FUSE_MERGE) else $error("strap path wrong");
  a_pullup_slave: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_PULLUP_PROBE && pullup_clk_seen && pullup_data_seen
    |=> stage_reg == HBSS_HOSTBUS_CFG && hostbus_slave) else $error("no slave");
  a_hostbus_wait: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_HOSTBUS_CFG && !end_hit |=> stage_reg == HBSS_HOSTBUS_CFG)
    else $error("left host-bus stage early");
  a_nospi_rom: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_FLASH_PROBE && !spi_mode_strap |=> stage_reg == HBSS_ROM_DEF && !ext_rom_en)
    else $error("no-SPI path wrong");
  a_connect_bits: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_CONNECT |=> superspeed_hub_on && attach_reg) else $error("attach bits not set");
  a_soft_disc: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_NORMAL && soft_disconnect |=> stage_reg == HBSS_CONNECT)
    else $error("soft disconnect ignored");
  a_straps_hold: assert property (@(posedge mclk) disable iff (reset)
    straps_done_reg |=> $stable(sel_reg) && $stable(pdis_reg)) else $error("straps resampled");
  a_release_probe: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_STANDBY |=> stage_reg == HBSS_FLASH_PROBE) else $error("no probe");
  a_merge_connect: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_FUSE_MERGE && $past(stage_reg) != HBSS_FUSE_MERGE
    |=> ##1 stage_reg == HBSS_CONNECT) else $error("merge timing");
  // ---------------------------------
  // Checks on boot steps
  // ---------------------------------
  // Flash probe has no timeout: a silent flash with SPI strapped stalls boot
  sequence s_last_byte;
    stage_reg == HBSS_FLASH_PROBE && spi_mode_strap && pll_valid_clk && flash_valid &&
      cnt_reg == `HBSS_SIG_BYTES - 3'h1;
  endsequence
  sequence s_merge_write;
    stage_reg == HBSS_FUSE_MERGE && mph_reg == 2'h1;
  endsequence
  a_standby_quiet: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_STANDBY |-> ports_hiz && port_enable == {`HBSS_NPORT{1'b0}})
    else $error("standby not quiet");
  a_run_live: assert property (@(posedge mclk) disable iff (reset)
    stage_reg != HBSS_STANDBY |-> !ports_hiz && pll_run) else $error("hub mode not live");
  a_probe_req: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_FLASH_PROBE && spi_mode_strap |-> flash_req) else $error("no flash req");
  a_probe_wait: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_FLASH_PROBE && spi_mode_strap && !(pll_valid_clk && flash_valid)
    |=> stage_reg == HBSS_FLASH_PROBE && $stable(cnt_reg)) else $error("byte counted early");
  a_sig_last: assert property (@(posedge mclk) disable iff (reset)
    s_last_byte |=> stage_reg == HBSS_ROM_DEF) else $error("probe did not end");
  a_sig_good: assert property (@(posedge mclk) disable iff (reset)
    s_last_byte ##0 ({sig_reg[23:0], flash_data} == `HBSS_SIG_WORD)
    |=> ext_rom_en && flash_addr == `HBSS_BOOT_ADDR) else $error("signature not taken");
  a_sig_bad: assert property (@(posedge mclk) disable iff (reset)
    s_last_byte ##0 ({sig_reg[23:0], flash_data} != `HBSS_SIG_WORD && !ext_rom_en)
    |=> !ext_rom_en) else $error("bad signature taken");
  a_rom_load: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_ROM_DEF |-> (cif.we && cif.waddr == `HBSS_IDX_ROM)
    ##1 stage_reg == HBSS_STRAP_READ) else $error("rom defaults skipped");
  a_strap_take: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_STRAP_READ && !straps_done_reg
    |=> cfg_select == $past(config_select_straps)
    && nonremovable == $past(nonremovable_strap)
    && charging_en == $past(charging_enable_strap)
    && pdis_reg == ($past(port_disable_plus_strap) | $past(port_disable_minus_strap)))
    else $error("straps not taken");
  a_pullup_miss: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_PULLUP_PROBE && !(pullup_clk_seen && pullup_data_seen)
    |=> stage_reg == HBSS_FUSE_MERGE && !hostbus_slave) else $error("missing pull-up ignored");
  a_slave_held: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_HOSTBUS_CFG |-> hostbus_slave) else $error("host-bus stage not slave");
  a_host_store: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_HOSTBUS_CFG && host_wr && host_reg != `HBSS_END_REG
    |-> cif.we && cif.wdata == host_wdata) else $error("host write lost");
  a_end_unstored: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_HOSTBUS_CFG && host_wr && host_reg == `HBSS_END_REG |-> !cif.we)
    else $error("end write stored");
  a_keep_cmd: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_HOSTBUS_CFG && end_hit && !legacy_mode &&
    host_opcode == `HBSS_CMD_ATTACH_KEEP |=> keep_hostbus) else $error("keep command lost");
  a_rom_otp_wins: assert property (@(posedge mclk) disable iff (reset)
    s_merge_write ##0 (!ext_reg && otp_data != 8'h00) |=> merged_cfg == $past(otp_data))
    else $error("otp did not win");
  a_flash_trim: assert property (@(posedge mclk) disable iff (reset)
    s_merge_write ##0 (ext_reg && !host_touched_reg)
    |=> merged_cfg == ($past(otp_data) & `HBSS_TRIM_MASK)) else $error("otp not masked");
  a_attach_normal: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_CONNECT && !soft_disconnect |=> stage_reg == HBSS_NORMAL && host_attach)
    else $error("connect did not attach");
  a_normal_hold: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_NORMAL && !soft_disconnect |=> stage_reg == HBSS_NORMAL)
    else $error("normal mode left");
  a_ports_off: assert property (@(posedge mclk) disable iff (reset)
    stage_reg != HBSS_NORMAL |-> port_enable == {`HBSS_NPORT{1'b0}}) else $error("port on early");
  a_disc_drop: assert property (@(posedge mclk) disable iff (reset)
    stage_reg == HBSS_CONNECT && soft_disconnect |-> !host_attach ##1 stage_reg == HBSS_CONNECT)
    else $error("disconnect kept attach");
endmodule
`default_nettype wire

// >>> testbench/hbss_partner.sv
// Far-side model: serial flash byte source and host-bus configuration master
// Assumes the bench raises go for one cycle once the sequencer waits for the master
`timescale 1ns/10ps
`default_nettype none
module hbss_partner (
  input wire logic mclk,
  input wire logic reset,
  input wire logic flash_req,
  input wire logic [19:0] flash_addr,
  input wire logic sig_good,
  input wire logic slow,
  input wire logic go,
  input wire logic [1:0] end_mode,
  output logic flash_valid,
  output logic [7:0] flash_data,
  output logic host_wr,
  output logic [7:0] host_reg,
  output logic [7:0] host_wdata,
  output logic host_cmd,
  output logic [15:0] host_opcode
);
  // ----------------------------------------
  // Flash and master behaviour
  // ----------------------------------------
  logic [31:0] img;
  logic gap;
  logic g;
  int step;
  int i;
  initial begin
    {flash_valid, flash_data, host_wr, host_reg, host_wdata, host_cmd, host_opcode} = '0;
    gap = 1'b0;
    step = 0;
  end
  // Bad image differs only in its last byte, the hardest miss to see
  assign img = sig_good ? 32'h32444655 : 32'h32444656;
  always @(posedge mclk) begin
    g = go;
    #1;
    // Released lines toggle so a stale byte is never mistaken for data
    flash_valid = 1'b0;
    flash_data = ~flash_data;
    host_wr = 1'b0;
    host_cmd = 1'b0;
    host_reg = ~host_reg;
    host_wdata = ~host_wdata;
    host_opcode = ~host_opcode;
    gap = slow & ~gap;
    if (flash_req && !reset && !gap) begin
      i = int'(flash_addr - 20'h3FFFA);
      flash_valid = 1'b1;
      flash_data = img[8*(3-i) +: 8];
    end
    if (g) begin
      step = 1;
    end else if (step != 0 && step < 3) begin
      step++;
    end else begin
      step = 0;
    end
    if (step == 1) begin
      host_wr = 1'b1;
      host_reg = 8'h10;
      host_wdata = 8'h5A;
    end
    if (step == 3) begin
      if (end_mode == 2'h0) begin
        host_wr = 1'b1;
        host_reg = 8'hFF;
        host_wdata = 8'h01;
      end else begin
        host_cmd = 1'b1;
        host_opcode = (end_mode == 2'h1) ? 16'hAA55 : 16'hAA56;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/hbss_tb_top.sv
// Bench for the hub boot stage sequencer
// Assumes the design files and the far-side model are compiled first
`timescale 1ns/10ps
`default_nettype none
module hub_boot_stage_sequencer_tb_top;
  import hbss_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic mclk, reset, pll, spi, nonrem, chg, fv, hwr, hcmd, pclk, pdat, legacy, sdis;
  logic sg, slow, go, freq, hiz, pllr, ext, slave, keep, att, ss, nrem_o, chg_o;
  logic [1:0] em;
  logic [2:0] sel, sel_o;
  logic [4:0] plus, minus, pen;
  logic [7:0] fd, hreg, hwd, otp, mcfg;
  logic [15:0] hop;
  logic [19:0] faddr;
  hbss_stage_t stage;
  int err_count, tests_run, hb, n;
  typedef struct {logic spi, sg, slow; logic [2:0] sel; logic pu; logic [1:0] em;
                  logic ext, slave, keep;} hbss_row_t;
  hbss_row_t rows[5] = '{
    '{1, 1, 0, 3'h1, 1, 2'h0, 1, 1, 0}, '{1, 0, 1, 3'h1, 1, 2'h1, 0, 1, 0},
    '{0, 1, 0, 3'h1, 1, 2'h2, 0, 1, 1}, '{1, 1, 1, 3'h2, 1, 2'h0, 1, 0, 0},
    '{0, 0, 0, 3'h1, 0, 2'h0, 0, 0, 0}};
  hbss_top dut_u (.mclk(mclk), .reset(reset), .pll_valid_clk(pll), .spi_mode_strap(spi),
    .config_select_straps(sel), .port_disable_plus_strap(plus),
    .port_disable_minus_strap(minus), .nonremovable_strap(nonrem),
    .charging_enable_strap(chg), .flash_req(freq), .flash_addr(faddr), .flash_valid(fv),
    .flash_data(fd), .pullup_clk_seen(pclk), .pullup_data_seen(pdat), .host_wr(hwr),
    .host_reg(hreg), .host_wdata(hwd), .host_cmd(hcmd), .host_opcode(hop),
    .legacy_mode(legacy), .otp_data(otp), .soft_disconnect(sdis), .ports_hiz(hiz),
    .pll_run(pllr), .ext_rom_en(ext), .hostbus_slave(slave), .keep_hostbus(keep),
    .host_attach(att), .superspeed_hub_on(ss), .port_enable(pen), .merged_cfg(mcfg),
    .cfg_select(sel_o), .nonremovable(nrem_o), .charging_en(chg_o), .stage(stage));
  hbss_partner far_u (.mclk(mclk), .reset(reset), .flash_req(freq), .flash_addr(faddr),
    .sig_good(sg), .slow(slow), .go(go), .end_mode(em), .flash_valid(fv), .flash_data(fd),
    .host_wr(hwr), .host_reg(hreg), .host_wdata(hwd), .host_cmd(hcmd), .host_opcode(hop));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Bounded wait; a stage never reached ends the run
  task automatic wait_stage(input hbss_stage_t s);
    for (n = 0; n < 400 && stage !== s; n++) begin
      @(posedge mclk);
      #1;
      if (stage === HBSS_HOSTBUS_CFG) hb++;
      go = (hb == 100);
    end
    if (stage !== s) begin
      err_count++;
      $display("CHECK FAILED stage expected %0d seen %0d", s, stage);
      tally_and_finish();
    end
  endtask
  task automatic boot(input hbss_row_t r, input int k);
    reset = 1'b1;
    repeat (20) @(posedge mclk);
    #1;
    {spi, sg, slow, sel, pdat, em} = {r.spi, r.sg, r.slow, r.sel, r.pu, r.em};
    legacy = (r.em == 2'h0);
    plus = 5'h01 << k;
    minus = 5'h02;
    nonrem = k[0];
    chg = ~k[0];
    hb = 0;
    chk("hiz", 1, hiz);
    chk("pll", 0, pllr);
    reset = 1'b0;
    @(posedge mclk);
    #1;
    chk("first", HBSS_FLASH_PROBE, stage);
    chk("freq", r.spi, freq);
    if (r.spi) chk("addr", 20'h3FFFA, faddr);
    wait_stage(HBSS_NORMAL);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset, pll, spi, sel, plus, minus, nonrem, chg, pclk, pdat, legacy, sdis} = '1;
    {sg, slow, go, em, err_count, tests_run} = '0;
    otp = 8'hC3;
    sdis = 1'b0;
    for (int k = 0; k < 5; k++) begin
      boot(rows[k], k);
      chk("ext", rows[k].ext, ext);
      chk("slave", rows[k].slave, slave);
      chk("waited", rows[k].slave, hb >= 100);
      chk("keep", rows[k].keep, keep);
      chk("attach", 1, att);
      chk("ss", 1, ss);
      chk("sel", rows[k].sel, sel_o);
      chk("nrem", k[0], nrem_o);
      chk("chg", 1'(~k[0]), chg_o);
      chk("pen", 5'(~((5'h01 << k) | 5'h02)), pen);
      if (rows[k].ext) begin
        chk("trim", 8'hC0, mcfg & 8'hC0);
        chk("boot", 20'h00000, faddr);
      end else begin
        chk("merge", 8'hC3, mcfg);
      end
      $display("test row %0d done", k);
    end
    // Straps changed after boot must not reach the outputs
    sel = 3'h6;
    nonrem = ~nonrem;
    repeat (3) @(posedge mclk);
    #1;
    chk("sel_hold", 3'h1, sel_o);
    chk("nrem_hold", 1'b0, nrem_o);
    $display("test strap hold done");
    sdis = 1'b1;
    wait_stage(HBSS_CONNECT);
    repeat (5) @(posedge mclk);
    #1;
    chk("sd_stage", HBSS_CONNECT, stage);
    chk("sd_att", 0, att);
    sdis = 1'b0;
    wait_stage(HBSS_NORMAL);
    chk("sd_back", 1, att);
    $display("test soft disconnect done");
    // Reset lands between edges: the drop must not wait for a clock
    @(posedge mclk);
    #1;
    reset = 1'b1;
    #1;
    chk("rst_stage", HBSS_STANDBY, stage);
    chk("rst_hiz", 1, hiz);
    chk("rst_pll", 0, pllr);
    chk("rst_pen", 0, pen);
    chk("rst_ext", 0, ext);
    chk("rst_att", 0, att);
    chk("rst_cfg", 0, mcfg);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
